// file: logic/lcdp_dev.sv
`timescale 1ns/10ps
module lcdp_dev #(
   parameter int RESET_CYC = lcdp_pkg::RESET_CYC
) (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   lcdp_if.dev             bus,
   output      logic       cmd_valid,
   output      logic       cmd_rs,
   output      logic [7:0] cmd_byte,
   output      logic       busy_indicator,
   output      logic [6:0] address_pointer,
   output      logic       nibble_mode,
   output      logic       osc_tick,
   output      logic       pump_clk,
   output      logic       frame_tick,
   output      logic       reset_ok,
   output      logic       ptr_inc
);
   typedef struct packed {
      logic [2:0]  rs_s, rd_s, stb_s;
      logic [7:0]  d1, d2;
      logic        nib;
      logic        half;
      logic [3:0]  hi;
      logic [7:0]  rdat;
      logic [7:0]  oe;
      logic        vld;
      logic        rs;
      logic [7:0]  byt;
      logic        busy;
      logic [2:0]  bcnt;
      logic [6:0]  ptr;
      logic        inc;
      logic [10:0] odiv;
      logic        otick;
      logic [2:0]  pdiv;
      logic        pclk;
      logic [10:0] fcnt;
      logic        ftick;
      logic [17:0] rcnt;
      logic        rok;
   } lcdp_dev_t;
   lcdp_dev_t s, n;
   logic strobe_fall, rd;
   logic [7:0] wbyte;
   always_comb begin
      n = s;
      n.rs_s  = {s.rs_s[1:0], bus.register_select};
      n.rd_s  = {s.rd_s[1:0], bus.read_sel};
      n.stb_s = {s.stb_s[1:0], bus.strobe};
      n.d1 = bus.host_data;
      n.d2 = s.d1;
      strobe_fall = s.stb_s[2] && !s.stb_s[1];
      rd = s.rd_s[1];
      // Commands are decoded from the assembled byte, not the last access.
      wbyte = s.nib ? {s.hi, s.d2[7:4]} : s.d2;
      n.vld = 1'b0;
      n.otick = 1'b0;
      n.ftick = 1'b0;
      // Oscillator base of 12.5 us from the system clock.
      if (s.odiv == 11'(lcdp_pkg::OSC_DIV - 1)) begin
         n.odiv = '0;
         n.otick = 1'b1;
      end else begin
         n.odiv = s.odiv + 1'b1;
      end
      if (s.otick) begin
         // Pump clock toggles so a full period is eight base ticks.
         if (s.pdiv == 3'(lcdp_pkg::PUMP_DIV / 2 - 1)) begin
            n.pdiv = '0;
            n.pclk = !s.pclk;
         end else begin
            n.pdiv = s.pdiv + 1'b1;
         end
         // Frame of 1080 base ticks gives 13.5 ms.
         if (s.fcnt == 11'(lcdp_pkg::FRAME_TICKS - 1)) begin
            n.fcnt = '0;
            n.ftick = 1'b1;
         end else begin
            n.fcnt = s.fcnt + 1'b1;
         end
         // Busy lasts a fixed count of base ticks.
         if (s.busy) begin
            if (s.bcnt == 3'(lcdp_pkg::BUSY_TICKS - 1)) begin
               n.busy = 1'b0;
               n.bcnt = '0;
            end else begin
               n.bcnt = s.bcnt + 1'b1;
            end
         end
      end
      // An asynchronous reset cannot be timed, so a settle timer after
      // release stands in for the minimum reset width.
      if (s.rcnt != 18'(RESET_CYC)) begin
         n.rcnt = s.rcnt + 1'b1;
      end else begin
         n.rok = 1'b1;
      end
      if (strobe_fall) begin
         if (rd) begin
            n.oe = '0;
         end else if (s.nib && !s.half) begin
            // High half is stored; low half completes the byte.
            n.hi = s.d2[7:4];
            n.half = 1'b1;
         end else begin
            n.vld = 1'b1;
            n.rs = s.rs_s[2];
            n.byt = wbyte;
            n.half = 1'b0;
            n.busy = 1'b1;
            n.bcnt = '0;
            if (s.rs_s[2]) begin
               n.ptr = s.inc ? s.ptr + 1'b1 : s.ptr - 1'b1;
            end else if ((wbyte & lcdp_pkg::ENTRY_MASK)
                         == lcdp_pkg::ENTRY_VAL) begin
               n.inc = wbyte[lcdp_pkg::ENTRY_ID_BIT];
            end else if ((wbyte & lcdp_pkg::CMD_FSET_MASK)
                         == lcdp_pkg::CMD_FSET_VAL) begin
               // Width change resets the half toggle.
               n.nib = !wbyte[lcdp_pkg::FSET_DL_BIT];
               n.half = 1'b0;
            end else if (wbyte[7]) begin
               n.ptr = wbyte[6:0];
            end
         end
      end
      if (s.stb_s[1] && !s.stb_s[2] && rd) begin
         // Status read offers busy and pointer, split in nibble mode.
         n.rdat = s.rs_s[1] ? 8'h00 : {s.busy, s.ptr};
         if (s.nib) begin
            n.rdat = s.half ? {n.rdat[3:0], 4'h0} : n.rdat;
            n.half = !s.half;
            n.oe = 8'hf0;
         end else begin
            n.oe = 8'hff;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.inc <= 1'b1;
         s.nib <= !lcdp_pkg::WIDTH_RESET;
      end else begin
         s <= n;
      end
   end
   assign bus.dev_data    = s.rdat;
   assign bus.dev_data_oe = s.oe;
   assign cmd_valid       = s.vld;
   assign cmd_rs          = s.rs;
   assign cmd_byte        = s.byt;
   assign busy_indicator  = s.busy;
   assign address_pointer = s.ptr;
   assign nibble_mode     = s.nib;
   assign osc_tick        = s.otick;
   assign pump_clk        = s.pclk;
   assign frame_tick      = s.ftick;
   assign reset_ok        = s.rok;
   assign ptr_inc         = s.inc;
endmodule

// file: logic/lcdp_pkg.sv
package lcdp_pkg;
   localparam int    SYS_CLK_HZ     = 100_000_000;
   localparam int    OSC_HZ         = 80_000;
   localparam int    OSC_DIV        = SYS_CLK_HZ / OSC_HZ;
   localparam int    PUMP_HZ        = 10_000;
   localparam int    PUMP_DIV       = OSC_HZ / PUMP_HZ;
   localparam int    FRAME_US_X10   = 135_000;
   localparam int    OSC_PERIOD_X10 = 125;
   localparam int    FRAME_TICKS    = FRAME_US_X10 / OSC_PERIOD_X10;
   localparam int    RESET_US       = 1_200;
   localparam int    RESET_CYC      = RESET_US * (SYS_CLK_HZ / 1_000_000);
   localparam int    BUSY_TICKS     = 4;
   localparam int    PTR_W          = 7;
   localparam logic [7:0] CMD_ENTRY_INC = 8'h06;
   localparam logic [7:0] CMD_FSET_MASK = 8'he0;
   localparam logic [7:0] CMD_FSET_VAL  = 8'h20;
   localparam int    FSET_DL_BIT    = 4;
   localparam int    ENTRY_ID_BIT   = 1;
   localparam logic [7:0] ENTRY_MASK    = 8'hfc;
   localparam logic [7:0] ENTRY_VAL     = 8'h04;
   localparam logic       WIDTH_RESET   = 1'b1;
   localparam int    FIFO_DEPTH     = 8;
endpackage

// file: logic/lcdp_if.sv
`timescale 1ns/10ps
interface lcdp_if;
   logic       register_select;
   logic       read_sel;
   logic       strobe;
   logic [7:0] host_data;
   logic [7:0] host_data_oe;
   logic [7:0] dev_data;
   logic [7:0] dev_data_oe;
   modport dev (input register_select, read_sel, strobe, host_data,
                output dev_data, dev_data_oe);
   modport host (output register_select, read_sel, strobe, host_data,
                 host_data_oe, input dev_data);
endinterface

// file: logic/lcdp_fifo.sv
`timescale 1ns/10ps
module lcdp_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } lcdp_fifo_t;
   lcdp_fifo_t s, next_s;
   logic push, pop;
   assign in_ready  = (s.cnt != (AW+1)'(D));
   assign out_valid = (s.cnt != '0);
   assign out_data  = s.mem[s.rp];
   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wp] = in_data;
         next_s.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
      end
      if (pop) begin
         next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
      end
      next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// file: logic/lcdp_host.sv
`timescale 1ns/10ps
module lcdp_host #(
   parameter int DEPTH = lcdp_pkg::FIFO_DEPTH,
   parameter int PHASE = 8
) (
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   lcdp_if.host            bus,
   input  wire logic       req_valid,
   output      logic       req_ready,
   input  wire logic       req_rs,
   input  wire logic [7:0] req_byte,
   input  wire logic       nibble_mode,
   output      logic       done
);
   typedef enum logic [2:0] {IDLE, WSET, WHI, POLL, PHI} lcdp_st_t;
   typedef struct packed {
      lcdp_st_t   st;
      logic [7:0] cnt;
      logic       half;
      logic       rs;
      logic       rd;
      logic       stb;
      logic [7:0] d;
      logic [7:0] oe;
      logic       pop;
      logic       done;
      logic       wid;
      logic [7:0] ds2;
      logic [7:0] ds3;
      logic       busy_hi;
   } lcdp_host_t;
   lcdp_host_t s, n;
   logic       f_valid, f_ready;
   logic [8:0] f_data;
   lcdp_fifo #(.W(9), .D(DEPTH)) i_lcdp_fifo (
      .sys_clk   (sys_clk),
      .rstn      (rstn),
      .in_valid  (req_valid),
      .in_ready  (req_ready),
      .in_data   ({req_rs, req_byte}),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );
   assign f_ready = s.pop;
   always_comb begin
      n = s;
      n.pop = 1'b0;
      n.done = 1'b0;
      n.ds2 = bus.dev_data;
      n.ds3 = s.ds2;
      n.cnt = s.cnt + 1'b1;
      case (s.st)
         IDLE: begin
            n.cnt = '0;
            if (f_valid && !s.pop) begin
               n.st = WSET;
               n.rs = f_data[8];
               n.wid = nibble_mode;
               n.rd = 1'b0;
               n.half = 1'b0;
               n.oe = nibble_mode ? 8'hf0 : 8'hff;
               n.d = f_data[7:0];
            end
         end
         WSET: begin
            n.stb = (s.cnt < 8'(PHASE));
            if (s.cnt == 8'(2 * PHASE)) begin
               n.cnt = '0;
               if (s.wid && !s.half) begin
                  n.half = 1'b1;
                  n.d = {s.d[3:0], 4'h0};
               end else begin
                  n.st = POLL;
                  n.pop = 1'b1;
                  n.rs = 1'b0;
                  n.rd = 1'b1;
                  n.oe = '0;
                  n.half = 1'b0;
                  // Poll in the width that this write has just chosen.
                  if (!f_data[8] && (f_data[7:0] & lcdp_pkg::CMD_FSET_MASK)
                      == lcdp_pkg::CMD_FSET_VAL) begin
                     n.wid = !f_data[lcdp_pkg::FSET_DL_BIT];
                  end
               end
            end
         end
         POLL: begin
            n.stb = (s.cnt < 8'(PHASE));
            if (s.cnt == 8'(PHASE - 1) && !s.half) begin
               n.busy_hi = s.ds3[7];
            end
            if (s.cnt == 8'(2 * PHASE)) begin
               n.cnt = '0;
               if (s.wid && !s.half) begin
                  n.half = 1'b1;
               end else if (!s.busy_hi) begin
                  n.st = IDLE;
                  n.done = 1'b1;
                  n.rd = 1'b0;
               end else begin
                  n.half = 1'b0;
               end
            end
         end
         default: n.st = IDLE;
      endcase
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.busy_hi <= 1'b1;
      end else begin
         s <= n;
      end
   end
   assign bus.register_select = s.rs;
   assign bus.read_sel        = s.rd;
   assign bus.strobe          = s.stb;
   assign bus.host_data       = s.d;
   assign bus.host_data_oe    = s.oe;
   assign done                = s.done;
endmodule

// file: tb/lcdp_props.sv
`timescale 1ns/10ps
module lcdp_props (
   input wire logic       sys_clk,
   input wire logic       rstn,
   input wire logic       strobe,
   input wire logic       register_select,
   input wire logic       read_sel,
   input wire logic [7:0] host_data_oe,
   input wire logic [7:0] dev_data_oe,
   input wire logic       cmd_valid,
   input wire logic       cmd_rs,
   input wire logic [7:0] cmd_byte,
   input wire logic       busy_indicator,
   input wire logic [6:0] address_pointer,
   input wire logic       nibble_mode,
   input wire logic       osc_tick,
   input wire logic       pump_clk,
   input wire logic       ptr_inc
);
   int   osc_cnt;
   int   pump_cnt;
   logic osc_seen;
   logic pump_seen;
   logic pump_prev;
   logic pump_edge;
   assign pump_edge = pump_clk != pump_prev;
   // The first tick or edge after reset has no known phase, so skip it.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         osc_cnt   <= 0;
         pump_cnt  <= 0;
         osc_seen  <= 1'b0;
         pump_seen <= 1'b0;
         pump_prev <= 1'b0;
      end else begin
         osc_cnt   <= osc_tick ? 0 : osc_cnt + 1;
         pump_cnt  <= pump_edge ? 0 : pump_cnt + 1;
         osc_seen  <= osc_seen | osc_tick;
         pump_seen <= pump_seen | pump_edge;
         pump_prev <= pump_clk;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence s_fset;
      cmd_valid && !cmd_rs && (cmd_byte & lcdp_pkg::CMD_FSET_MASK)
         == lcdp_pkg::CMD_FSET_VAL;
   endsequence
   sequence s_entry;
      cmd_valid && !cmd_rs && (cmd_byte & lcdp_pkg::ENTRY_MASK)
         == lcdp_pkg::ENTRY_VAL;
   endsequence
   property p_no_clash;
      (host_data_oe & dev_data_oe) == 8'h00;
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("bus clash");
   property p_ctl_stable;
      strobe && $past(strobe) |-> $stable(register_select) && $stable(read_sel);
   endproperty
   a_ctl_stable: assert property (p_ctl_stable) else $error("ctl moved");
   property p_cmd_pulse;
      cmd_valid |=> !cmd_valid;
   endproperty
   a_cmd_pulse: assert property (p_cmd_pulse) else $error("cmd twice");
   property p_osc;
      osc_tick && osc_seen |-> osc_cnt == 1249;
   endproperty
   a_osc: assert property (p_osc) else $error("osc period");
   property p_pump;
      pump_edge && pump_seen |-> pump_cnt == 4999;
   endproperty
   a_pump: assert property (p_pump) else $error("pump period");
   property p_ptr_step;
      cmd_valid && cmd_rs |-> address_pointer
         == (ptr_inc ? $past(address_pointer) + 7'h01
                     : $past(address_pointer) - 7'h01);
   endproperty
   a_ptr_step: assert property (p_ptr_step) else $error("ptr step");
   property p_width;
      s_fset |=> nibble_mode == !$past(cmd_byte[lcdp_pkg::FSET_DL_BIT]);
   endproperty
   a_width: assert property (p_width) else $error("width");
   property p_entry;
      s_entry |=> ptr_inc == $past(cmd_byte[lcdp_pkg::ENTRY_ID_BIT]);
   endproperty
   a_entry: assert property (p_entry) else $error("entry dir");
   property p_busy_hold;
      $rose(busy_indicator) |-> busy_indicator [*8];
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy short");
   property p_nib_oe;
      nibble_mode && dev_data_oe != 8'h00 |-> dev_data_oe == 8'hf0;
   endproperty
   a_nib_oe: assert property (p_nib_oe) else $error("nibble oe");
endmodule

// file: tb/lcdp_test.sv
`timescale 1ns/10ps
module lcdp_test;
   logic       sys_clk, rstn, req_valid, req_rs, host_nib, req_ready, done;
   logic       cmd_valid, cmd_rs, busy_indicator, nibble_mode, ptr_inc;
   logic       osc_tick, pump_clk, reset_ok;
   logic [7:0] req_byte, cmd_byte, last_byte;
   logic [6:0] address_pointer;
   int         fail_count, num_checks, acc;
   lcdp_if bus_if();
   lcdp_dev #(.RESET_CYC(16)) i_lcdp_dev (.sys_clk(sys_clk), .rstn(rstn),
      .bus(bus_if), .cmd_valid(cmd_valid), .cmd_rs(cmd_rs),
      .cmd_byte(cmd_byte), .busy_indicator(busy_indicator),
      .address_pointer(address_pointer), .nibble_mode(nibble_mode),
      .osc_tick(osc_tick), .pump_clk(pump_clk), .frame_tick(),
      .reset_ok(reset_ok), .ptr_inc(ptr_inc));
   lcdp_host #(.DEPTH(8), .PHASE(8)) i_lcdp_host (.sys_clk(sys_clk),
      .rstn(rstn), .bus(bus_if), .req_valid(req_valid),
      .req_ready(req_ready), .req_rs(req_rs), .req_byte(req_byte),
      .nibble_mode(host_nib), .done(done));
   lcdp_props i_lcdp_props (.sys_clk(sys_clk), .rstn(rstn),
      .strobe(bus_if.strobe), .register_select(bus_if.register_select),
      .read_sel(bus_if.read_sel), .host_data_oe(bus_if.host_data_oe),
      .dev_data_oe(bus_if.dev_data_oe), .cmd_valid(cmd_valid),
      .cmd_rs(cmd_rs), .cmd_byte(cmd_byte), .busy_indicator(busy_indicator),
      .address_pointer(address_pointer), .nibble_mode(nibble_mode),
      .osc_tick(osc_tick), .pump_clk(pump_clk), .ptr_inc(ptr_inc));
   always @(posedge sys_clk) begin
      if (cmd_valid === 1'b1) begin
         last_byte <= cmd_byte;
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Requests are raised at a falling edge and held until a rising edge
   // has seen ready, so the FIFO never takes a half-changed request.
   task automatic xfer(input logic rs, input logic [7:0] b);
      int i;
      @(negedge sys_clk);
      req_valid = 1'b1;
      req_rs = rs;
      req_byte = b;
      for (i = 0; i < 200 && req_ready !== 1'b1; i++) begin
         @(negedge sys_clk);
      end
      if (i == 200) begin
         fail_count++;
         stop_test();
      end
      @(negedge sys_clk);
      req_valid = 1'b0;
      for (i = 0; i < 20000 && done !== 1'b1; i++) begin
         @(posedge sys_clk) #1;
      end
      if (i == 20000) begin
         fail_count++;
         stop_test();
      end
   endtask
   task automatic t_wide();
      check({6'h0, nibble_mode, ptr_inc}, 8'h01);
      check({7'h0, reset_ok}, 8'h00);
      xfer(1'b0, 8'h06);
      check({7'h0, reset_ok}, 8'h01);
      check(last_byte, 8'h06);
      check({7'h0, ptr_inc}, 8'h01);
      xfer(1'b0, 8'h28);
      check({7'h0, nibble_mode}, 8'h01);
      @(negedge sys_clk);
      host_nib = 1'b1;
   endtask
   task automatic t_nibble();
      xfer(1'b1, 8'ha5);
      check(last_byte, 8'ha5);
      check({1'b0, address_pointer}, 8'h01);
      xfer(1'b0, 8'h04);
      check({7'h0, ptr_inc}, 8'h00);
      xfer(1'b1, 8'h5a);
      check(last_byte, 8'h5a);
      check({1'b0, address_pointer}, 8'h00);
      xfer(1'b0, 8'h06);
   endtask
   // Bytes are queued one per cycle, faster than the host writes them, so the queue fills up.
   task automatic t_fill();
      int k;
      @(negedge sys_clk);
      req_valid = 1'b1;
      req_rs = 1'b1;
      req_byte = 8'h00;
      acc = 0;
      for (k = 0; k < 40 && req_ready === 1'b1; k++) begin
         @(negedge sys_clk);
         acc++;
         req_byte = acc[7:0];
      end
      req_valid = 1'b0;
      check(8'(acc > 7), 8'h01);
      for (k = 0; k < acc; k++) begin
         xfer_wait();
      end
      check(last_byte, acc[7:0] - 8'h01);
      check({1'b0, address_pointer}, acc[7:0]);
   endtask
   task automatic xfer_wait();
      int i;
      @(posedge sys_clk) #1;
      for (i = 0; i < 20000 && done !== 1'b1; i++) begin
         @(posedge sys_clk) #1;
      end
      if (i == 20000) begin
         fail_count++;
         stop_test();
      end
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial begin
      {rstn, req_valid, req_rs, host_nib, req_byte} = 12'h000;
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      rstn = 1'b1;
      t_wide();
      t_nibble();
      t_fill();
      stop_test();
   end
endmodule
